// ---- logic/vlid_decoder.sv ----
// Variable-length instruction field decoder: byte stream in, decoded fields out
//
// Contract
// - accept 1 to 15 byte instructions, any alignment
// - over 15 bytes raises fault, code zero
// - prefixes, opcode, modrm, sib, disp, imm order
// - prefixes affect only the next instruction
// - prefix order does not change result; the code lets the last of two segment overrides win
// - segment override codes select memory segment
// - 66h inverts default operand size
// - 67h inverts default address size
// - F0h holds bus lock during execution
// - F2h/F3h mark string instruction for repeat
// - one or two byte opcodes recognised
// - group opcodes resolved by modrm reg field
// - width bit picks 8 or full size
// - direction bit swaps source and destination
// - sign-extend bit widens byte immediate
// - extract mode, reg/mem and register fields
// - extract scale and index from sib byte
// - narrow and wide segment selector fields
// - special-register selector field extracted
// - width clear, codes 100-111 are high bytes
//
// The plain strobed port and the register offsets were left to the implementer.
module vlid_decoder
	import vlid_pkg::*;
#(
	parameter int MAX_LEN = vlid_pkg::INSN_MAX_LEN
) (
	input wire logic clk, // Core clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic in_valid, // Prefetch byte valid
	input wire logic [7:0] in_byte, // Prefetch byte
	output logic in_ready, // Decoder takes the byte
	output logic out_valid, // Decoded instruction valid
	output vlid_pkg::vlid_insn_s out_insn, // Decoded fields
	input wire logic out_ready, // Pipeline takes the instruction
	output logic gp_fault, // Length fault pulse
	output logic [15:0] gp_err_code, // Fault error code
	input wire logic exec_done, // Pipeline finished the issued instruction
	output logic bus_lock, // Bus lock held during execution
	input wire logic [7:0] reg_addr, // Register address
	input wire logic [31:0] reg_wdata, // Register write data
	input wire logic reg_we, // Register write strobe
	input wire logic reg_re, // Register read strobe
	output logic [31:0] reg_rdata // Read data, cycle after strobe
);
	import vlid_pkg::*;

	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	if (MAX_LEN < 1 || MAX_LEN > 15) begin : g_bad_len
		$error("MAX_LEN must lie between 1 and 15");
	end

	localparam logic [3:0] LEN_LIMIT = 4'(MAX_LEN);

	typedef enum {ST_PFX, ST_OP2, ST_MODRM, ST_SIB, ST_DISP, ST_IMM, ST_OUT} vlid_state_e;

	// ------------------------------------------------------------
	// Lookup functions
	// ------------------------------------------------------------

	// Modrm presence and immediate kind of an opcode
	function automatic logic [2:0] op_info(input logic two, input logic [7:0] op);
		logic m;
		logic [1:0] k;
		m = 1'b0;
		k = IMM_NONE;
		if (two) begin
			if (op[7:4] == 4'h8) begin
				k = IMM_FULL;
			end else begin
				m = 1'b1;
			end
		end else if (op[7:6] == 2'b00 && op[2:1] != 2'b11) begin
			m = ~op[2];
			k = op[2] ? (op[0] ? IMM_FULL : IMM_BYTE) : IMM_NONE;
		end else begin
			case (op)
				8'h80, 8'h82, 8'h83, 8'hc6: begin
					m = 1'b1;
					k = IMM_BYTE;
				end
				8'h81, 8'hc7, 8'h69: begin
					m = 1'b1;
					k = IMM_FULL;
				end
				8'h6b: begin
					m = 1'b1;
					k = IMM_BYTE;
				end
				8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d,
				8'h8e, 8'h8f, 8'hc0, 8'hc1, 8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hf6, 8'hf7,
				8'hfe, 8'hff: begin
					m = 1'b1;
					k = (op == 8'hc0 || op == 8'hc1) ? IMM_BYTE : IMM_NONE;
				end
				8'h6a, 8'ha8, 8'heb, 8'hcd: k = IMM_BYTE;
				8'h68, 8'ha9, 8'he8, 8'he9: k = IMM_FULL;
				default: begin
					if (op[7:4] == 4'h7 || op[7:3] == 5'h16) begin
						k = IMM_BYTE;
					end else if (op[7:3] == 5'h17) begin
						k = IMM_FULL;
					end
				end
			endcase
		end
		return {m, k};
	endfunction : op_info

	// Byte count of an immediate kind at the current operand size
	function automatic logic [2:0] imm_bytes(input logic [1:0] kind, input logic op32);
		case (kind)
			IMM_BYTE: return 3'h1;
			IMM_FULL: return op32 ? 3'h4 : 3'h2;
			default: return 3'h0;
		endcase
	endfunction : imm_bytes

	// Displacement byte count from the addressing-mode byte
	function automatic logic [2:0] disp_bytes(input logic ad32, input logic [1:0] md,
		input logic [2:0] rm);
		case (md)
			2'b00: return (ad32 && rm == 3'h5) ? 3'h4 : ((!ad32 && rm == 3'h6) ? 3'h2 : 3'h0);
			2'b01: return 3'h1;
			2'b10: return ad32 ? 3'h4 : 3'h2;
			default: return 3'h0;
		endcase
	endfunction : disp_bytes

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	vlid_state_e st_r, st_nxt;
	vlid_insn_s ins_r, ins_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic fault_r, fault_nxt;
	logic lock_r, lock_nxt;
	logic [1:0] ctrl_r, ctrl_nxt;
	logic [15:0] icnt_r, icnt_nxt;
	logic [15:0] fcnt_r, fcnt_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic take;
	logic op32_cur;
	logic ad32_cur;

	assign in_ready = (st_r != ST_OUT);
	assign take = in_valid && in_ready;
	// Prefix flags hold toggles until the instruction is complete
	assign op32_cur = ctrl_r[CTRL_OP32_BIT] ^ ins_r.op32;
	assign ad32_cur = ctrl_r[CTRL_AD32_BIT] ^ ins_r.ad32;

	// ------------------------------------------------------------
	// Decode sequencer
	// ------------------------------------------------------------

	// Next state, field capture and finalisation of one instruction
	always_comb begin
		logic [2:0] info;
		logic go_tail;
		logic done;
		info = 3'h0;
		go_tail = 1'b0;
		done = 1'b0;
		st_nxt = st_r;
		ins_nxt = ins_r;
		cnt_nxt = cnt_r;
		fault_nxt = 1'b0;
		if (st_r == ST_OUT) begin
			if (out_ready) begin
				st_nxt = ST_PFX;
				ins_nxt = '0;
			end
		end else if (take) begin
			if (ins_r.len == LEN_LIMIT) begin
				fault_nxt = 1'b1;
				st_nxt = ST_PFX;
				ins_nxt = '0;
				cnt_nxt = 3'h0;
			end else begin
				ins_nxt.len = ins_r.len + 4'h1;
				case (st_r)
					ST_PFX: begin
						// Each prefix sets its own flag, except segment overrides, which share seg so the last one wins
						case (in_byte)
							PFX_ES: begin
								ins_nxt.seg_ovr = 1'b1;
								ins_nxt.seg = SEG_ES;
							end
							PFX_CS: begin
								ins_nxt.seg_ovr = 1'b1;
								ins_nxt.seg = SEG_CS;
							end
							PFX_SS: begin
								ins_nxt.seg_ovr = 1'b1;
								ins_nxt.seg = SEG_SS;
							end
							PFX_DS: begin
								ins_nxt.seg_ovr = 1'b1;
								ins_nxt.seg = SEG_DS;
							end
							PFX_FS: begin
								ins_nxt.seg_ovr = 1'b1;
								ins_nxt.seg = SEG_FS;
							end
							PFX_GS: begin
								ins_nxt.seg_ovr = 1'b1;
								ins_nxt.seg = SEG_GS;
							end
							PFX_OPSZ: ins_nxt.op32 = 1'b1;
							PFX_ADSZ: ins_nxt.ad32 = 1'b1;
							PFX_LOCK: ins_nxt.lock = 1'b1;
							PFX_REPEAT_WHILE_UNEQUAL_PREFIX: ins_nxt.rep_ne = 1'b1;
							PFX_REPE: ins_nxt.rep_e = 1'b1;
							OP_ESC: begin
								ins_nxt.two_byte = 1'b1;
								st_nxt = ST_OP2;
							end
							default: begin
								info = op_info(1'b0, in_byte);
								ins_nxt.opcode = in_byte;
								ins_nxt.imm_len = imm_bytes(info[1:0], op32_cur);
								if (info[2]) begin
									st_nxt = ST_MODRM;
								end else begin
									go_tail = 1'b1;
								end
							end
						endcase
					end
					ST_OP2: begin
						info = op_info(1'b1, in_byte);
						ins_nxt.opcode = in_byte;
						ins_nxt.imm_len = imm_bytes(info[1:0], op32_cur);
						if (info[2]) begin
							st_nxt = ST_MODRM;
						end else begin
							go_tail = 1'b1;
						end
					end
					ST_MODRM: begin
						ins_nxt.has_modrm = 1'b1;
						ins_nxt.mode = in_byte[7:6];
						ins_nxt.reg_sel = in_byte[5:3];
						ins_nxt.rm = in_byte[2:0];
						// Test form of the unary group carries an immediate
						if (!ins_r.two_byte && ins_r.opcode[7:1] == 7'h7b && in_byte[5:3] == 3'h0) begin
							ins_nxt.imm_len = imm_bytes(ins_r.opcode[0] ? IMM_FULL : IMM_BYTE,
								op32_cur);
						end
						ins_nxt.disp_len = disp_bytes(ad32_cur, in_byte[7:6], in_byte[2:0]);
						if (ad32_cur && in_byte[7:6] != 2'b11 && in_byte[2:0] == 3'h4) begin
							st_nxt = ST_SIB;
						end else begin
							go_tail = 1'b1;
						end
					end
					ST_SIB: begin
						ins_nxt.has_sib = 1'b1;
						ins_nxt.scale = in_byte[7:6];
						ins_nxt.index = in_byte[5:3];
						ins_nxt.base = in_byte[2:0];
						if (in_byte[2:0] == 3'h5 && ins_r.mode == 2'b00) begin
							ins_nxt.disp_len = 3'h4;
						end
						go_tail = 1'b1;
					end
					ST_DISP: begin
						ins_nxt.disp[{cnt_r[1:0], 3'h0} +: 8] = in_byte;
						cnt_nxt = cnt_r + 3'h1;
						if (cnt_r + 3'h1 == ins_r.disp_len) begin
							cnt_nxt = 3'h0;
							if (ins_r.imm_len != 3'h0) begin
								st_nxt = ST_IMM;
							end else begin
								done = 1'b1;
							end
						end
					end
					ST_IMM: begin
						ins_nxt.imm[{cnt_r[1:0], 3'h0} +: 8] = in_byte;
						cnt_nxt = cnt_r + 3'h1;
						if (cnt_r + 3'h1 == ins_r.imm_len) begin
							cnt_nxt = 3'h0;
							done = 1'b1;
						end
					end
					default: st_nxt = ST_PFX;
				endcase
			end
		end
		// Pick the first remaining tail field after opcode, modrm or sib
		if (go_tail) begin
			cnt_nxt = 3'h0;
			if (ins_nxt.disp_len != 3'h0) begin
				st_nxt = ST_DISP;
			end else if (ins_nxt.imm_len != 3'h0) begin
				st_nxt = ST_IMM;
			end else begin
				done = 1'b1;
			end
		end
		// Derive small fields once every byte is in
		if (done) begin
			st_nxt = ST_OUT;
			ins_nxt.op32 = op32_cur;
			ins_nxt.ad32 = ad32_cur;
			ins_nxt.w = ins_nxt.opcode[0];
			ins_nxt.d = ins_nxt.opcode[1];
			ins_nxt.s = !ins_nxt.two_byte && ins_nxt.opcode[7:2] == 6'h20 && ins_nxt.opcode[1];
			ins_nxt.opnd_bits = ins_nxt.w ? (op32_cur ? 6'h20 : 6'h10) : 6'h08;
			ins_nxt.reg_is_src = !ins_nxt.d;
			ins_nxt.group_ext = ins_nxt.reg_sel;
			ins_nxt.seg_select_narrow = ins_nxt.opcode[4:3];
			ins_nxt.seg_select_wide = ins_nxt.reg_sel;
			ins_nxt.special_reg = ins_nxt.reg_sel;
			ins_nxt.reg_high_byte = !ins_nxt.w && ins_nxt.reg_sel[2];
			if (ins_nxt.s && ins_nxt.imm_len == 3'h1) begin
				ins_nxt.imm[31:8] = op32_cur ? {24{ins_nxt.imm[7]}}
					: {16'h0000, {8{ins_nxt.imm[7]}}};
			end
		end
	end

	// Sequencer registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= ST_PFX;
			ins_r <= '0;
			cnt_r <= 3'h0;
			fault_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			ins_r <= ins_nxt;
			cnt_r <= cnt_nxt;
			fault_r <= fault_nxt;
		end
	end

	assign out_valid = (st_r == ST_OUT);
	assign out_insn = ins_r;
	assign gp_fault = fault_r;
	assign gp_err_code = GP_ERR_CODE;

	// ------------------------------------------------------------
	// Bus lock
	// ------------------------------------------------------------

	// Lock rises on issue of a locked instruction, falls on its completion
	always_comb begin
		lock_nxt = lock_r;
		if (exec_done) begin
			lock_nxt = 1'b0;
		end
		if (st_r == ST_OUT && out_ready && ins_r.lock) begin
			lock_nxt = 1'b1;
		end
	end

	// Lock register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lock_r <= 1'b0;
		end else begin
			lock_r <= lock_nxt;
		end
	end

	assign bus_lock = lock_r;

	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------

	// Mode control, event counters and read data
	always_comb begin
		ctrl_nxt = ctrl_r;
		icnt_nxt = icnt_r;
		fcnt_nxt = fcnt_r;
		rdata_nxt = 32'h0000_0000;
		if (reg_we && reg_addr == REG_CTRL) begin
			ctrl_nxt = reg_wdata[1:0];
		end
		if (reg_we && reg_addr == REG_COUNT) begin
			icnt_nxt = 16'h0000;
			fcnt_nxt = 16'h0000;
		end
		// Counting after the clear keeps a same-cycle event
		if (st_r == ST_OUT && out_ready) begin
			icnt_nxt = icnt_nxt + 16'h0001;
		end
		if (fault_r) begin
			fcnt_nxt = fcnt_nxt + 16'h0001;
		end
		if (reg_re) begin
			case (reg_addr)
				REG_CTRL: rdata_nxt = {30'h0000_0000, ctrl_r};
				REG_COUNT: rdata_nxt = {fcnt_r, icnt_r};
				REG_STATE: rdata_nxt = {24'h00_0000, lock_r, cnt_r, ins_r.len};
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	// Register port flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= CTRL_RESET;
			icnt_r <= 16'h0000;
			fcnt_r <= 16'h0000;
			rdata_r <= 32'h0000_0000;
		end else begin
			ctrl_r <= ctrl_nxt;
			icnt_r <= icnt_nxt;
			fcnt_r <= fcnt_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata = rdata_r;

endmodule : vlid_decoder

// ---- logic/vlid_pkg.sv ----
// Shared constants and types for the variable-length instruction field decoder
package vlid_pkg;

	// ------------------------------------------------------------
	// Length limits
	// ------------------------------------------------------------
	localparam int INSN_MAX_LEN = 15;
	localparam logic [15:0] GP_ERR_CODE = 16'h0000;

	// ------------------------------------------------------------
	// Prefix and escape codes
	// ------------------------------------------------------------
	localparam logic [7:0] PFX_ES = 8'h26;
	localparam logic [7:0] PFX_CS = 8'h2e;
	localparam logic [7:0] PFX_SS = 8'h36;
	localparam logic [7:0] PFX_DS = 8'h3e;
	localparam logic [7:0] PFX_FS = 8'h64;
	localparam logic [7:0] PFX_GS = 8'h65;
	localparam logic [7:0] PFX_OPSZ = 8'h66;
	localparam logic [7:0] PFX_ADSZ = 8'h67;
	localparam logic [7:0] PFX_LOCK = 8'hf0;
	localparam logic [7:0] PFX_REPEAT_WHILE_UNEQUAL_PREFIX = 8'hf2;
	localparam logic [7:0] PFX_REPE = 8'hf3;
	localparam logic [7:0] OP_ESC = 8'h0f;

	// ------------------------------------------------------------
	// Segment codes as driven on the seg field
	// ------------------------------------------------------------
	localparam logic [2:0] SEG_ES = 3'h0;
	localparam logic [2:0] SEG_CS = 3'h1;
	localparam logic [2:0] SEG_SS = 3'h2;
	localparam logic [2:0] SEG_DS = 3'h3;
	localparam logic [2:0] SEG_FS = 3'h4;
	localparam logic [2:0] SEG_GS = 3'h5;

	// ------------------------------------------------------------
	// Immediate kinds from the opcode lookup
	// ------------------------------------------------------------
	localparam logic [1:0] IMM_NONE = 2'h0;
	localparam logic [1:0] IMM_BYTE = 2'h1;
	localparam logic [1:0] IMM_FULL = 2'h2;

	// ------------------------------------------------------------
	// Register port map and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_COUNT = 8'h04;
	localparam logic [7:0] REG_STATE = 8'h08;
	localparam int CTRL_OP32_BIT = 0;
	localparam int CTRL_AD32_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;

	// ------------------------------------------------------------
	// Decoded instruction handed to the pipeline
	// ------------------------------------------------------------
	typedef struct packed {
		logic [3:0] len;
		logic two_byte;
		logic [7:0] opcode;
		logic has_modrm;
		logic [1:0] mode;
		logic [2:0] rm;
		logic [2:0] reg_sel;
		logic has_sib;
		logic [1:0] scale;
		logic [2:0] index;
		logic [2:0] base;
		logic [2:0] disp_len;
		logic [31:0] disp;
		logic [2:0] imm_len;
		logic [31:0] imm;
		logic w;
		logic d;
		logic s;
		logic op32;
		logic ad32;
		logic seg_ovr;
		logic [2:0] seg;
		logic lock;
		logic rep_ne;
		logic rep_e;
		logic [2:0] group_ext;
		logic [1:0] seg_select_narrow;
		logic [2:0] seg_select_wide;
		logic [2:0] special_reg;
		logic reg_is_src;
		logic reg_high_byte;
		logic [5:0] opnd_bits;
	} vlid_insn_s;

endpackage : vlid_pkg

// ---- tb/vlid_decoder_assertions.sv ----
// Port checks for the instruction field decoder
module vlid_decoder_assertions
	import vlid_pkg::*;
#(
	parameter int MAX_LEN = 15
) (
	input wire logic clk, // Core clock
	input wire logic rst_n, // Reset, active low
	input wire logic in_valid, // Byte valid
	input wire logic [7:0] in_byte, // Byte
	input wire logic in_ready, // Byte taken
	input wire logic out_valid, // Insn valid
	input wire vlid_pkg::vlid_insn_s out_insn, // Fields
	input wire logic out_ready, // Insn taken
	input wire logic gp_fault, // Fault pulse
	input wire logic [15:0] gp_err_code, // Fault code
	input wire logic exec_done, // Execution end
	input wire logic bus_lock, // Lock level
	input wire logic [7:0] reg_addr, // Reg address
	input wire logic [31:0] reg_wdata, // Reg data
	input wire logic reg_we, // Write strobe
	input wire logic reg_re, // Read strobe
	input wire logic [31:0] reg_rdata // Read data
);
	timeunit 1ns;
	timeprecision 1ps;
	import vlid_pkg::*;
	// ------------------------------------------------------------
	// Relations over time
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Handover of an instruction, with and without lock
	sequence s_take;
		out_valid && out_ready;
	endsequence
	sequence s_lock_issue;
		out_valid && out_ready && out_insn.lock;
	endsequence
	property p_err_zero;
		gp_fault |-> gp_err_code == 16'h0000;
	endproperty
	a_err_zero: assert property (p_err_zero) else $error("fault code not zero");
	property p_fault_pulse;
		gp_fault |=> !gp_fault;
	endproperty
	a_fault_pulse: assert property (p_fault_pulse) else $error("fault not one cycle");
	property p_len;
		out_valid |-> out_insn.len >= 4'h1 && out_insn.len <= MAX_LEN;
	endproperty
	a_len: assert property (p_len) else $error("length out of range");
	property p_hold;
		out_valid && !out_ready |=> out_valid && $stable(out_insn) && !in_ready;
	endproperty
	a_hold: assert property (p_hold) else $error("offer changed while waiting");
	property p_release;
		s_take |=> !out_valid;
	endproperty
	a_release: assert property (p_release) else $error("offer kept after take");
	property p_lock_set;
		s_lock_issue |=> bus_lock;
	endproperty
	a_lock_set: assert property (p_lock_set) else $error("lock not raised");
	property p_lock_end;
		exec_done && !(out_valid && out_ready && out_insn.lock) |=> !bus_lock;
	endproperty
	a_lock_end: assert property (p_lock_end) else $error("lock not dropped");
	property p_lock_hold;
		bus_lock && !exec_done |=> bus_lock;
	endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("lock dropped early");
	property p_high_byte;
		out_valid && out_insn.has_modrm |->
			out_insn.reg_high_byte == (!out_insn.w && out_insn.reg_sel[2]);
	endproperty
	a_high_byte: assert property (p_high_byte) else $error("high byte wrong");
	property p_dir;
		out_valid && out_insn.has_modrm |-> out_insn.reg_is_src == !out_insn.d;
	endproperty
	a_dir: assert property (p_dir) else $error("direction wrong");
	property p_group;
		out_valid && !out_insn.two_byte && out_insn.opcode[7:2] == 6'h20 |->
			out_insn.group_ext == out_insn.reg_sel;
	endproperty
	a_group: assert property (p_group) else $error("group field wrong");
endmodule : vlid_decoder_assertions

bind vlid_decoder vlid_decoder_assertions #(.MAX_LEN(MAX_LEN)) u_vlid_decoder_assertions (
	.clk(clk), .rst_n(rst_n), .in_valid(in_valid), .in_byte(in_byte), .in_ready(in_ready),
	.out_valid(out_valid), .out_insn(out_insn), .out_ready(out_ready), .gp_fault(gp_fault),
	.gp_err_code(gp_err_code), .exec_done(exec_done), .bus_lock(bus_lock),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
	.reg_rdata(reg_rdata));

// ---- tb/vlid_pipe_model.sv ----
// Pipeline model: takes decoded instructions and reports execution end
module vlid_pipe_model (
	input wire logic clk, // Core clock
	input wire logic rst_n, // Reset, active low
	input wire logic out_valid, // Insn offered
	output logic out_ready, // Insn taken
	output logic exec_done, // Execution end pulse
	input wire logic [3:0] stall, // Cycles before taking
	input wire logic [3:0] ex_lat // Execution cycles, at least one
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_r;
	logic [3:0] ex_r;
	// ------------------------------------------------------------
	// Take after the stall, then execute for ex_lat cycles
	// ------------------------------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_r <= 4'h0;
			ex_r <= 4'h0;
			out_ready <= 1'b0;
			exec_done <= 1'b0;
		end else begin
			out_ready <= 1'b0;
			wait_r <= 4'h0;
			if (out_valid && !out_ready) begin
				out_ready <= wait_r >= stall;
				wait_r <= wait_r + 4'h1;
			end
			if (out_valid && out_ready)
				ex_r <= ex_lat;
			else if (ex_r != 4'h0)
				ex_r <= ex_r - 4'h1;
			exec_done <= ex_r == 4'h1; // Ends any bus lock
		end
	end
endmodule : vlid_pipe_model

// ---- tb/vlid_decoder_tb_top.sv ----
// Self-checking bench for the instruction field decoder
module vlid_decoder_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import vlid_pkg::*;
	typedef struct {
		int n;
		logic [63:0] b;
		logic [3:0] len;
		logic [31:0] imm;
		logic [11:0] fl;
		int k;
		logic [14:0] mr;
		logic [5:0] ob;
	} vlid_row_s;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic in_valid = 1'b0;
	logic [7:0] in_byte = 8'h00;
	logic in_ready, out_valid, out_ready, gp_fault, exec_done, bus_lock;
	vlid_insn_s out_insn;
	vlid_insn_s o;
	logic [15:0] gp_err_code;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_we = 1'b0;
	logic reg_re = 1'b0;
	logic [31:0] reg_rdata;
	logic [3:0] stall = 4'h2;
	logic [3:0] ex_lat = 4'h2;
	int err_total = 0;
	int samples_checked = 0;
	// Bytes first-lowest; fl {op32,ad32,ovr,seg,lock,rne,re,w,d,s}; k 0 none, 1 modrm, 2 sib
	vlid_row_s rows [20] = '{
		'{3, 64'h05c083, 4'h3, 32'h5, 12'h007, 1, 15'h6000, 6'h10},
		'{3, 64'hffc083, 4'h3, 32'hffff, 12'h007, 1, 15'h6000, 6'h10},
		'{3, 64'h7ff880, 4'h3, 32'h7f, 12'h000, 1, 15'h63e0, 6'h08},
		'{2, 64'he500, 4'h2, 32'h0, 12'h000, 1, 15'h7660, 6'h08},
		'{3, 64'hd80366, 4'h3, 32'h0, 12'h806, 1, 15'h6180, 6'h20},
		'{2, 64'hd803, 4'h2, 32'h0, 12'h006, 1, 15'h6180, 6'h10},
		'{4, 64'h88048b67, 4'h4, 32'h0, 12'h406, 2, 15'h1011, 6'h10},
		'{4, 64'h1234840f, 4'h4, 32'h1234, 12'h000, 0, 15'h0, 6'h0},
		'{2, 64'h9026, 4'h2, 32'h0, 12'h200, 0, 15'h0, 6'h0},
		'{2, 64'h902e, 4'h2, 32'h0, 12'h240, 0, 15'h0, 6'h0},
		'{2, 64'h9036, 4'h2, 32'h0, 12'h280, 0, 15'h0, 6'h0},
		'{2, 64'h903e, 4'h2, 32'h0, 12'h2c0, 0, 15'h0, 6'h0},
		'{2, 64'h9064, 4'h2, 32'h0, 12'h300, 0, 15'h0, 6'h0},
		'{2, 64'h9065, 4'h2, 32'h0, 12'h340, 0, 15'h0, 6'h0},
		'{2, 64'h90f0, 4'h2, 32'h0, 12'h020, 0, 15'h0, 6'h0},
		'{2, 64'h90f2, 4'h2, 32'h0, 12'h010, 0, 15'h0, 6'h0},
		'{2, 64'h90f3, 4'h2, 32'h0, 12'h008, 0, 15'h0, 6'h0},
		'{3, 64'h902666, 4'h3, 32'h0, 12'ha00, 0, 15'h0, 6'h0},
		'{3, 64'h906626, 4'h3, 32'h0, 12'ha00, 0, 15'h0, 6'h0},
		'{3, 64'h10468b, 4'h3, 32'h0, 12'h006, 1, 15'h3800, 6'h10}
	};
	// Core clock, 8 ns period
	always #4 clk = ~clk;
	vlid_decoder #(.MAX_LEN(15)) u_vlid_decoder (
		.clk(clk), .rst_n(rst_n), .in_valid(in_valid), .in_byte(in_byte), .in_ready(in_ready),
		.out_valid(out_valid), .out_insn(out_insn), .out_ready(out_ready), .gp_fault(gp_fault),
		.gp_err_code(gp_err_code), .exec_done(exec_done), .bus_lock(bus_lock),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
		.reg_rdata(reg_rdata));
	vlid_pipe_model u_vlid_pipe_model (.clk(clk), .rst_n(rst_n), .out_valid(out_valid),
		.out_ready(out_ready), .exec_done(exec_done), .stall(stall), .ex_lat(ex_lat));
	// ------------------------------------------------------------
	// Compare, closing and bus tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic end_sim();
		$display("checked=%0d errors=%0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	// Waits at falling edges for 0 in_ready, 1 out_valid, 2 gp_fault
	task automatic wait_hi(input int w);
		int t;
		logic s;
		t = 0;
		do begin
			@(negedge clk);
			t++;
			s = w == 0 ? in_ready : (w == 1 ? out_valid : gp_fault);
		end while (s !== 1'b1 && t < 64);
		if (s !== 1'b1) begin
			err_total++;
			end_sim();
		end
	endtask : wait_hi
	// One byte, held until the edge that takes it
	task automatic put(input logic [7:0] b);
		in_valid <= 1'b1;
		in_byte <= b;
		wait_hi(0);
		@(posedge clk);
	endtask : put
	task automatic send(input int n, input logic [63:0] b);
		@(posedge clk);
		for (int i = 0; i < n; i++)
			put(b[8*i +: 8]);
		in_valid <= 1'b0;
	endtask : send
	task automatic get();
		wait_hi(1);
		o = out_insn;
	endtask : get
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_we <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_we <= 1'b0;
	endtask : reg_wr
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_re <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_re <= 1'b0;
		@(negedge clk);
		chk(reg_rdata, exp);
	endtask : rd_chk
	// ------------------------------------------------------------
	// Main sequence: table, then hand-written cases
	// ------------------------------------------------------------
	initial begin
		vlid_row_s r;
		logic [11:0] m;
		logic [14:0] mm;
		repeat (9) @(posedge clk);
		@(negedge clk);
		chk({in_ready, out_valid, bus_lock, gp_fault}, 32'h8);
		@(posedge clk);
		rst_n <= 1'b1;
		rd_chk(REG_CTRL, 32'h0);
		rd_chk(8'hfc, 32'h0);
		foreach (rows[i]) begin
			r = rows[i];
			send(r.n, r.b);
			get();
			chk(o.len, r.len);
			m = r.fl[9] ? 12'hfff : 12'he3f;
			chk({o.op32, o.ad32, o.seg_ovr, o.seg, o.lock, o.rep_ne, o.rep_e, o.w, o.d, o.s} & m,
				r.fl);
			chk(o.has_modrm, r.k > 0);
			chk(o.has_sib, r.k == 2);
			mm = r.k == 2 ? 15'h7fff : (r.k == 1 ? 15'h7fe0 : 15'h0);
			chk({o.mode, o.rm, o.reg_sel, o.reg_high_byte, o.reg_is_src, o.scale, o.index} & mm,
				r.mr);
			if (r.k > 0) chk(o.opnd_bits, r.ob);
			if (r.imm != 32'h0) chk(o.imm, r.imm);
			if (i == 2) chk(o.group_ext, 3'h7);
			if (i == 7) chk({o.two_byte, o.opcode}, 9'h184);
			if (i == 3) chk(o.seg_select_wide, 3'h4);
			if (i == 3) chk(o.special_reg, 3'h4);
			if (i == 8) chk(o.seg_select_narrow, 2'h2);
			if (i == 19) chk(o.disp, 32'h10);
		end
		// Lock held from handover until execution ends
		stall <= 4'h0;
		ex_lat <= 4'h8;
		send(2, 64'h90f0);
		get();
		repeat (4) @(negedge clk);
		chk(bus_lock, 1'b1);
		repeat (12) @(negedge clk);
		chk(bus_lock, 1'b0);
		// Sixteenth byte faults, next byte starts afresh
		@(posedge clk);
		repeat (15) put(8'h66);
		put(8'h90);
		in_valid <= 1'b0;
		wait_hi(2);
		chk(gp_err_code, 16'h0000);
		send(1, 64'h90);
		get();
		chk({o.len, o.op32}, 5'h02);
		@(posedge clk);
		repeat (14) put(8'h66);
		put(8'h90);
		in_valid <= 1'b0;
		get();
		chk(o.len, 4'hf);
		// Let the pipeline take the last instruction before counting
		repeat (2) @(posedge clk);
		rd_chk(REG_COUNT, 32'h00010017);
		reg_wr(REG_COUNT, 32'h0);
		rd_chk(REG_COUNT, 32'h0);
		// Prefixes invert 32-bit defaults
		reg_wr(REG_CTRL, 32'h3);
		rd_chk(REG_CTRL, 32'h3);
		send(2, 64'hd803);
		get();
		chk(o.opnd_bits, 6'h20);
		send(3, 64'hd80366);
		get();
		chk(o.opnd_bits, 6'h10);
		send(3, 64'h048b67);
		get();
		chk(o.ad32, 1'b0);
		chk({o.has_sib, o.len}, 5'h03);
		// Second reset clears the defaults
		@(posedge clk);
		rst_n <= 1'b0;
		@(negedge clk);
		chk({in_ready, out_valid, bus_lock, gp_fault}, 32'h8);
		@(posedge clk);
		rst_n <= 1'b1;
		rd_chk(REG_CTRL, 32'h0);
		end_sim();
	end
endmodule : vlid_decoder_tb_top
